// ==== bench/ebct_timer_asserts.sv ====
// Port-level checks for the eight-bit compare timer.
// Assumes a bind onto ebct_timer; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module ebct_timer_asserts #(
   parameter int CNT_W = 8   // Counter width
) (
   input wire logic clk_sys,                     // System clock
   input wire logic rst,                         // Synchronous reset
   input wire logic [2:0] clock_source_sel,      // Clock select
   input wire logic int_clock_sel_lo,            // Extra select bit
   input wire logic [1:0] clear_sel,             // Clear select
   input wire logic [3:0] output_action_sel,     // Output action
   input wire logic trigger_gate_enable,         // Gate enable
   input wire logic overflow_irq_en,             // Overflow irq enable
   input wire logic [CNT_W-1:0] compare_value_a, // Compare value A
   input wire logic clear_overflow_flag,         // Overflow flag clear
   input wire logic [CNT_W-1:0] up_counter,      // Counter
   input wire logic overflow_flag,               // Overflow flag
   input wire logic match_flag_a,                // Match flag A
   input wire logic irq_overflow,                // Overflow irq
   input wire logic timer_out_pin,               // Output pin
   input wire logic counting                     // Not halted
);
   // ****************************************
   // Counter, flag and output checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_count_step: assert property ($changed(up_counter) |->
      up_counter == $past(up_counter) + 1'b1 || up_counter == '0) else $error("bad counter step");
   a_stop_hold: assert property (($past({int_clock_sel_lo, 2'b00} ^ clock_source_sel) == 3'h0)
      && ({int_clock_sel_lo, 2'b00} ^ clock_source_sel) == 3'h0 && clear_sel == 2'h0
      |=> $stable(up_counter)) else $error("stopped counter moved");
   a_ovf_set: assert property ($past(up_counter) == '1 && up_counter == '0
      && $past(clear_sel) == 2'h0 |-> overflow_flag) else $error("wrap without flag");
   a_irq_mask: assert property (!overflow_irq_en && !$past(overflow_irq_en)
      |-> !irq_overflow) else $error("masked irq raised");
   a_match_set: assert property ($past(up_counter) == $past(compare_value_a)
      && up_counter == $past(up_counter) + 1'b1 |-> match_flag_a) else $error("match missed");
   a_toggle_out: assert property ($past(output_action_sel) == 4'h3
      && $past(up_counter) == $past(compare_value_a) && $changed(up_counter)
      |-> timer_out_pin != $past(timer_out_pin)) else $error("no toggle on match");
   a_match_clear: assert property ($past(clear_sel) == 2'h1
      && $past(up_counter) == $past(compare_value_a) && $changed(up_counter)
      |-> up_counter == '0 && match_flag_a) else $error("match clear missed");
   a_halt_hold: assert property (!counting |-> $stable(up_counter) || up_counter == '0)
      else $error("halted counter moved");
   a_gate_off: assert property (!trigger_gate_enable [*2] |-> counting)
      else $error("halt without gate");
   a_flag_sticky: assert property ($fell(overflow_flag) |-> $past(clear_overflow_flag))
      else $error("flag lost without clear");
   // Main scenarios reached
   c_ovf: cover property ($rose(overflow_flag));
   c_match: cover property ($rose(match_flag_a));
   c_halt: cover property ($fell(counting));
endmodule : ebct_timer_asserts
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the eight-bit compare timer.
// Assumes ebct_timer and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_sys, rst, intClockSelLo, triggerGateEnable, overflowIrqEn, matchIrqEnA;
   logic matchIrqEnB, clearOverflowFlag, clearMatchFlagA, clearMatchFlagB, extClockPin;
   logic extClearInput, triggerInputPin, overflowFlag, matchFlagA, matchFlagB, irqOverflow;
   logic irqMatchA, irqMatchB, timerOutPin, counting;
   logic [2:0] clockSourceSel;
   logic [1:0] clearSel, trigEdgeSel;
   logic [3:0] outputActionSel;
   logic [7:0] compareValueA, compareValueB, upCounter;
   int miscompares = 0;
   int nTests = 0;
   int i;
   // ****************************************
   // Device under test and clock
   // ****************************************
   ebct_timer #(.CNT_W(8)) dut (.clk_sys(clk_sys), .rst(rst), .clock_source_sel(clockSourceSel),
      .int_clock_sel_lo(intClockSelLo), .clear_sel(clearSel), .output_action_sel(outputActionSel),
      .trigger_gate_enable(triggerGateEnable), .trig_edge_sel(trigEdgeSel),
      .overflow_irq_en(overflowIrqEn), .match_irq_en_a(matchIrqEnA), .match_irq_en_b(matchIrqEnB),
      .compare_value_a(compareValueA), .compare_value_b(compareValueB),
      .clear_overflow_flag(clearOverflowFlag), .clear_match_flag_a(clearMatchFlagA),
      .clear_match_flag_b(clearMatchFlagB), .ext_clock_pin(extClockPin),
      .ext_clear_input(extClearInput), .trigger_input_pin(triggerInputPin),
      .up_counter(upCounter), .overflow_flag(overflowFlag), .match_flag_a(matchFlagA),
      .match_flag_b(matchFlagB), .irq_overflow(irqOverflow), .irq_match_a(irqMatchA),
      .irq_match_b(irqMatchB), .timer_out_pin(timerOutPin), .counting(counting));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons=%0d mismatches=%0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   // Ends the run when a bounded wait ran out
   task automatic limit(input int n, input int lim);
      if (n >= lim) begin
         miscompares++;
         report_and_stop();
      end
   endtask : limit
   // Defaults on every input, selected clock applied during reset
   task automatic do_reset(input logic [2:0] cs);
      rst = 1'b1;
      {intClockSelLo, clearSel, outputActionSel, triggerGateEnable, trigEdgeSel} = '0;
      {overflowIrqEn, matchIrqEnA, matchIrqEnB, clearOverflowFlag, clearMatchFlagA} = '0;
      {clearMatchFlagB, extClockPin, extClearInput, triggerInputPin} = '0;
      compareValueA = 8'hff;
      compareValueB = 8'hff;
      clockSourceSel = cs;
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
   endtask : do_reset
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_count;
      do_reset(3'h1);
      check({6'h00, counting, overflowFlag}, 8'h02);
      repeat (40) @(negedge clk_sys);
      check(upCounter, 8'h0a);
      clockSourceSel = 3'h0;
      repeat (20) @(negedge clk_sys);
      check(upCounter, 8'h0a);
      $display("count test done");
   endtask : t_count
   task automatic t_overflow;
      do_reset(3'h1);
      overflowIrqEn = 1'b1;
      for (i = 0; i < 1100 && overflowFlag !== 1'b1; i++) @(negedge clk_sys);
      limit(i, 1100);
      check(upCounter, 8'h00);
      check({6'h00, matchFlagB, irqMatchB}, 8'h02);
      @(negedge clk_sys);
      check({7'h00, irqOverflow}, 8'h01);
      overflowIrqEn = 1'b0;
      clearOverflowFlag = 1'b1;
      repeat (2) @(negedge clk_sys);
      clearOverflowFlag = 1'b0;
      check({6'h00, overflowFlag, irqOverflow}, 8'h00);
      $display("overflow test done");
   endtask : t_overflow
   // Waits for match flag A, with a bound
   task automatic wait_a;
      for (i = 0; i < 200 && matchFlagA !== 1'b1; i++) @(negedge clk_sys);
      limit(i, 200);
   endtask : wait_a
   task automatic t_match;
      do_reset(3'h1);
      {compareValueA, clearSel, outputActionSel, matchIrqEnA} = {8'h05, 2'h1, 4'h3, 1'b1};
      wait_a();
      check({upCounter[6:0], timerOutPin}, 8'h01);
      clearMatchFlagA = 1'b1;
      @(negedge clk_sys);
      clearMatchFlagA = 1'b0;
      @(negedge clk_sys);
      check({7'h00, matchFlagA}, 8'h00);
      // Clear held across the next match edge: the set must win
      repeat (21) @(negedge clk_sys);
      clearMatchFlagA = 1'b1;
      @(negedge clk_sys);
      clearMatchFlagA = 1'b0;
      check({7'h00, matchFlagA}, 8'h01);
      wait_a();
      @(negedge clk_sys);
      check({6'h00, timerOutPin, irqMatchA}, 8'h01);
      {compareValueB, clearSel, outputActionSel} = {8'h07, 2'h2, 4'h8};
      for (i = 0; i < 200 && matchFlagB !== 1'b1; i++) @(negedge clk_sys);
      limit(i, 200);
      check({upCounter[6:0], timerOutPin}, 8'h01);
      $display("match test done");
   endtask : t_match
   task automatic t_gate;
      do_reset(3'h1);
      {clearSel, triggerGateEnable, trigEdgeSel} = {2'h3, 1'b1, 2'h1};
      repeat (30) @(negedge clk_sys);
      extClearInput = 1'b1;
      repeat (ebct_pkg::CLR_PULSE_MIN_CYC) @(negedge clk_sys);
      extClearInput = 1'b0;
      repeat (8) @(negedge clk_sys);
      check({upCounter[6:0], counting}, 8'h00);
      repeat (20) @(negedge clk_sys);
      check(upCounter, 8'h00);
      triggerInputPin = 1'b1;
      for (i = 0; i < 12 && counting !== 1'b1; i++) @(negedge clk_sys);
      limit(i, 12);
      repeat (12) @(negedge clk_sys);
      check({7'h00, upCounter != 8'h00}, 8'h01);
      $display("gate test done");
   endtask : t_gate
   // External clock on both edges, high and low actions, falling trigger, divide by 32
   task automatic t_modes;
      do_reset(3'h3);
      {intClockSelLo, compareValueA, compareValueB} = {1'b1, 8'h02, 8'h04};
      {outputActionSel, matchIrqEnB} = {4'h6, 1'b1};
      for (i = 0; i < 6; i++) begin
         if (i == 3) begin
            check({upCounter[6:0], timerOutPin}, 8'h07);
         end
         extClockPin = ~extClockPin;
         repeat (4) @(negedge clk_sys);
      end
      check(upCounter, 8'h06);
      check({4'h0, timerOutPin, matchFlagA, matchFlagB, irqMatchB}, 8'h07);
      {clearSel, triggerGateEnable, trigEdgeSel, triggerInputPin} = {2'h3, 1'b1, 2'h2, 1'b1};
      extClearInput = 1'b1;
      repeat (ebct_pkg::CLR_PULSE_MIN_CYC) @(negedge clk_sys);
      {extClearInput, intClockSelLo, clockSourceSel} = {1'b0, 1'b0, 3'h4};
      repeat (6) @(negedge clk_sys);
      check({upCounter[6:0], counting}, 8'h00);
      triggerInputPin = 1'b0;
      repeat (8) @(negedge clk_sys);
      check({upCounter[6:0], counting}, 8'h01);
      repeat (24) @(negedge clk_sys);
      check(upCounter, 8'h01);
      $display("modes test done");
   endtask : t_modes
   initial begin
      do_reset(3'h0);
      t_count();
      t_overflow();
      t_match();
      t_gate();
      t_modes();
      report_and_stop();
   end
endmodule : testbench
bind ebct_timer ebct_timer_asserts #(.CNT_W(CNT_W)) chk (.clk_sys(clk_sys), .rst(rst),
   .clock_source_sel(clock_source_sel), .int_clock_sel_lo(int_clock_sel_lo),
   .clear_sel(clear_sel), .output_action_sel(output_action_sel),
   .trigger_gate_enable(trigger_gate_enable), .overflow_irq_en(overflow_irq_en),
   .compare_value_a(compare_value_a), .clear_overflow_flag(clear_overflow_flag),
   .up_counter(up_counter), .overflow_flag(overflow_flag), .match_flag_a(match_flag_a),
   .irq_overflow(irq_overflow), .timer_out_pin(timer_out_pin), .counting(counting));
`default_nettype wire

// ==== core/ebct_pkg.sv ====
// Constants and carrier types for the eight-bit compare timer.
// Assumes a single system clock; all control bits arrive as plain ports.
//
// How it works
// - Software picks one of seven clocks (four prescaled internal, three external edge modes) and counting starts once one is picked.
// - A wrap of the counter from its top value to zero sets the overflow flag.
// - The overflow interrupt request is raised only while its enable bit is 1.
// - The counter is compared with both compare values all the time and a match sets flag A or B.
// - The match signal is asserted in the last clock state in which counter and compare value are equal.
// - A match interrupt request for A or B is raised only while its enable bit is 1.
// - A match A or B drives the timer output pin with the action chosen by the four-bit output select.
// - Clear select 01 or 10 clears the counter on match A or match B.
// - Clear select 11 clears the counter on a rising edge of the external clear input.
// - With the trigger gate on, any clear source halts counting right after the counter clears.
// - After such a halt, counting resumes on the trigger input edge chosen by the edge select.
package ebct_pkg;

   // ****************************************
   // Clock selection codes: clock_source_sel with bit 2 inverted by int_clock_sel_lo
   // ****************************************
   localparam logic [2:0] CKS_STOP = 3'h0;
   localparam logic [2:0] CKS_DIV4 = 3'h1;
   localparam logic [2:0] CKS_DIV8 = 3'h2;
   localparam logic [2:0] CKS_DIV16 = 3'h3;
   localparam logic [2:0] CKS_DIV32 = 3'h4;
   localparam logic [2:0] CKS_EXT_RISE = 3'h5;
   localparam logic [2:0] CKS_EXT_FALL = 3'h6;
   localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
   localparam int PRESC_BITS = 8;
   localparam logic [PRESC_BITS-1:0] PRESC_RESET = 8'h00;

   // ****************************************
   // Counter clear select and trigger edge codes
   // ****************************************
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_MATCH_A = 2'h1;
   localparam logic [1:0] CLR_MATCH_B = 2'h2;
   localparam logic [1:0] CLR_EXT_PIN = 2'h3;
   localparam logic [1:0] TRG_NONE = 2'h0;
   localparam logic [1:0] TRG_RISE = 2'h1;
   localparam logic [1:0] TRG_FALL = 2'h2;
   localparam logic [1:0] TRG_BOTH = 2'h3;

   // ****************************************
   // Output action field: [3:2] on match B, [1:0] on match A
   // ****************************************
   localparam int OS_A_LSB = 0;
   localparam int OS_B_LSB = 2;
   localparam logic [1:0] OUT_KEEP = 2'h0;
   localparam logic [1:0] OUT_LOW = 2'h1;
   localparam logic [1:0] OUT_HIGH = 2'h2;
   localparam logic [1:0] OUT_TOGGLE = 2'h3;

   // ****************************************
   // Timing and reset values
   // ****************************************
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CLR_PULSE_MIN_PS = 12000;   // 1.5 system clocks
   localparam int CLR_PULSE_MIN_CYC = (CLR_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // Gate state; the run code is 1 so the gate flop drives the counting output
   typedef enum logic [0:0] {
      GATE_HALT = 1'b0,
      GATE_RUN = 1'b1
   } ebct_gate_t;

   // Synchroniser for a pin: three stages
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } ebct_sync_t;

   // Event flags
   typedef struct packed {
      logic overflowFlag;
      logic matchFlagA;
      logic matchFlagB;
   } ebct_flags_t;

   // Whole state of the timer
   typedef struct packed {
      logic [PRESC_BITS-1:0] presc;
      logic [7:0] upCounter;
      ebct_gate_t gate;
      ebct_sync_t extClk;
      ebct_sync_t extClr;
      ebct_sync_t trig;
      ebct_flags_t flags;
      logic matchA;
      logic matchB;
      logic timerOut;
      logic irqOvf;
      logic irqMatchA;
      logic irqMatchB;
   } ebct_state_t;

endpackage : ebct_pkg

// ==== core/ebct_timer.sv ====
// Eight-bit up counter with two compare values, flags and one output pin.
// Assumes pins are asynchronous and pass a three-stage synchroniser.
`timescale 1ns/1ns
`default_nettype none
module ebct_timer #(
   parameter int CNT_W = 8   // Counter width
) (
   input wire logic clk_sys,                     // System clock, 125 MHz
   input wire logic rst,                         // Synchronous reset, active high
   input wire logic [2:0] clock_source_sel,      // Prescaler clock select
   input wire logic int_clock_sel_lo,            // Extra internal clock select bit
   input wire logic [1:0] clear_sel,             // {clear_sel_hi, clear_sel_lo}
   input wire logic [3:0] output_action_sel,     // Output action on match
   input wire logic trigger_gate_enable,         // Gate counting with trigger
   input wire logic [1:0] trig_edge_sel,         // {trig_edge_sel_hi, trig_edge_sel_lo}
   input wire logic overflow_irq_en,             // Overflow interrupt enable
   input wire logic match_irq_en_a,              // Match A interrupt enable
   input wire logic match_irq_en_b,              // Match B interrupt enable
   input wire logic [CNT_W-1:0] compare_value_a, // Compare value A
   input wire logic [CNT_W-1:0] compare_value_b, // Compare value B
   input wire logic clear_overflow_flag,         // Pulse: clear overflow flag
   input wire logic clear_match_flag_a,          // Pulse: clear match flag A
   input wire logic clear_match_flag_b,          // Pulse: clear match flag B
   input wire logic ext_clock_pin,               // External count clock pin
   input wire logic ext_clear_input,             // External clear pin
   input wire logic trigger_input_pin,           // Trigger pin
   output logic [CNT_W-1:0] up_counter,          // Counter value
   output logic overflow_flag,                   // Sticky overflow flag
   output logic match_flag_a,                    // Sticky match flag A
   output logic match_flag_b,                    // Sticky match flag B
   output logic irq_overflow,                    // Overflow interrupt request
   output logic irq_match_a,                     // Match A interrupt request
   output logic irq_match_b,                     // Match B interrupt request
   output logic timer_out_pin,                   // Timer output pin
   output logic counting                         // High while the counter is not halted
);

   ebct_pkg::ebct_state_t st;
   ebct_pkg::ebct_state_t next_st;

   // Advance a three-stage synchroniser; level changes once s2 and s3 agree
   function automatic ebct_pkg::ebct_sync_t syncStep(input ebct_pkg::ebct_sync_t s,
                                                     input logic pin);
      ebct_pkg::ebct_sync_t r;
      r.s1 = pin;
      r.s2 = s.s1;
      r.s3 = s.s2;
      r.level = (s.s2 == s.s3) ? s.s3 : s.level;
      return r;
   endfunction : syncStep

   // Output action for one match
   function automatic logic outAction(input logic [1:0] act, input logic cur);
      case (act)
         ebct_pkg::OUT_LOW: outAction = 1'b0;
         ebct_pkg::OUT_HIGH: outAction = 1'b1;
         ebct_pkg::OUT_TOGGLE: outAction = ~cur;
         default: outAction = cur;
      endcase
   endfunction : outAction

   // ****************************************
   // Next-state logic
   // ****************************************
   logic [2:0] clkSel;
   logic tick;
   logic extRise;
   logic extFall;
   logic clrRise;
   logic trgRise;
   logic trgFall;
   logic trgHit;
   logic eqA;
   logic eqB;
   logic matchA;
   logic matchB;
   logic clearSrc;
   logic wrap;
   logic outVal;

   always_comb begin
      next_st = st;
      clkSel = {int_clock_sel_lo, 2'b00} ^ clock_source_sel;
      // Synchronise pins
      next_st.extClk = syncStep(st.extClk, ext_clock_pin);
      next_st.extClr = syncStep(st.extClr, ext_clear_input);
      next_st.trig = syncStep(st.trig, trigger_input_pin);
      extRise = next_st.extClk.level & ~st.extClk.level;
      extFall = ~next_st.extClk.level & st.extClk.level;
      clrRise = next_st.extClr.level & ~st.extClr.level;
      trgRise = next_st.trig.level & ~st.trig.level;
      trgFall = ~next_st.trig.level & st.trig.level;
      // Prescaler free-runs; select a count tick
      next_st.presc = st.presc + 8'h01;
      case (clkSel)
         ebct_pkg::CKS_DIV4: tick = (st.presc[1:0] == 2'h3);
         ebct_pkg::CKS_DIV8: tick = (st.presc[2:0] == 3'h7);
         ebct_pkg::CKS_DIV16: tick = (st.presc[3:0] == 4'hf);
         ebct_pkg::CKS_DIV32: tick = (st.presc[4:0] == 5'h1f);
         ebct_pkg::CKS_EXT_RISE: tick = extRise;
         ebct_pkg::CKS_EXT_FALL: tick = extFall;
         ebct_pkg::CKS_EXT_BOTH: tick = extRise | extFall;
         default: tick = 1'b0;
      endcase
      // Match is signalled in the last state of equality: on the tick that leaves it
      eqA = (st.upCounter == compare_value_a);
      eqB = (st.upCounter == compare_value_b);
      matchA = eqA & tick & (st.gate == ebct_pkg::GATE_RUN);
      matchB = eqB & tick & (st.gate == ebct_pkg::GATE_RUN);
      next_st.matchA = matchA;
      next_st.matchB = matchB;
      // Clear sources
      case (clear_sel)
         ebct_pkg::CLR_MATCH_A: clearSrc = matchA;
         ebct_pkg::CLR_MATCH_B: clearSrc = matchB;
         ebct_pkg::CLR_EXT_PIN: clearSrc = clrRise;
         default: clearSrc = 1'b0;
      endcase
      wrap = tick & (st.gate == ebct_pkg::GATE_RUN) & (st.upCounter == {CNT_W{1'b1}});
      // Counter and gate
      trgHit = 1'b0;
      case (trig_edge_sel)
         ebct_pkg::TRG_RISE: trgHit = trgRise;
         ebct_pkg::TRG_FALL: trgHit = trgFall;
         ebct_pkg::TRG_BOTH: trgHit = trgRise | trgFall;
         default: trgHit = 1'b0;
      endcase
      case (st.gate)
         ebct_pkg::GATE_RUN: begin
            if (clearSrc) begin
               next_st.upCounter = '0;
               if (trigger_gate_enable) begin
                  next_st.gate = ebct_pkg::GATE_HALT;
               end
            end else if (tick) begin
               next_st.upCounter = st.upCounter + 8'h01;
            end
         end
         ebct_pkg::GATE_HALT: begin
            if (clearSrc) begin
               next_st.upCounter = '0;
            end
            if (trgHit || !trigger_gate_enable) begin
               next_st.gate = ebct_pkg::GATE_RUN;
            end
         end
         default: next_st.gate = ebct_pkg::GATE_RUN;
      endcase
      // Sticky flags, set beats clear
      next_st.flags.overflowFlag = wrap | (st.flags.overflowFlag & ~clear_overflow_flag);
      next_st.flags.matchFlagA = matchA | (st.flags.matchFlagA & ~clear_match_flag_a);
      next_st.flags.matchFlagB = matchB | (st.flags.matchFlagB & ~clear_match_flag_b);
      // Interrupt requests follow flags and enables
      next_st.irqOvf = next_st.flags.overflowFlag & overflow_irq_en;
      next_st.irqMatchA = next_st.flags.matchFlagA & match_irq_en_a;
      next_st.irqMatchB = next_st.flags.matchFlagB & match_irq_en_b;
      // Output pin: match A then match B applied
      outVal = st.timerOut;
      if (matchA) begin
         outVal = outAction(output_action_sel[ebct_pkg::OS_A_LSB +: 2], outVal);
      end
      if (matchB) begin
         outVal = outAction(output_action_sel[ebct_pkg::OS_B_LSB +: 2], outVal);
      end
      next_st.timerOut = outVal;
      if (rst) begin
         next_st = '0;
         next_st.presc = ebct_pkg::PRESC_RESET;
         next_st.upCounter = ebct_pkg::COUNT_RESET;
         next_st.gate = ebct_pkg::GATE_RUN;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys) begin
      st <= next_st;
   end

   // Outputs straight from state
   assign up_counter = st.upCounter;
   assign overflow_flag = st.flags.overflowFlag;
   assign match_flag_a = st.flags.matchFlagA;
   assign match_flag_b = st.flags.matchFlagB;
   assign irq_overflow = st.irqOvf;
   assign irq_match_a = st.irqMatchA;
   assign irq_match_b = st.irqMatchB;
   assign timer_out_pin = st.timerOut;
   assign counting = st.gate;   // Gate flop, high in the run state

endmodule : ebct_timer
`default_nettype wire
